// ---- hw/swb_consts.svh ----
// Notes on behaviour
// - decode opcode 0101_10da ffff_ffff; result is reg minus w minus borrow.
// - direction bit 0 writes result into w, data register untouched.
// - direction bit 1 writes result back into addressed data register.
// - access bit 0 selects the fixed access bank, bank pointer ignored.
// - access bit 1 forms address from bank pointer and 8-bit field.
`ifndef SWB_CONSTS_SVH
`define SWB_CONSTS_SVH
`define SWB_OPC_MATCH 6'h16
`define SWB_OPC_HI 15
`define SWB_OPC_LO 10
`define SWB_DIR_BIT 9
`define SWB_ACC_BIT 8
`define SWB_ACC_BANK_HI 4'h0
`define SWB_ACC_SPLIT 8'h80
`define SWB_ACC_BANK_TOP 4'hf
`define SWB_W_RST 8'h00
`define SWB_BANK_RST 4'h0
`define SWB_MEM_DEPTH 4096
`endif

// ---- hw/swb_pkg.sv ----
package swb_pkg;
  typedef enum logic [1:0] {
    SWB_Q1,
    SWB_Q2,
    SWB_Q3,
    SWB_Q4
  } swb_phase_type;
endpackage

// ---- hw/swb_mem_if.sv ----
`timescale 1ns/1ps
interface swb_mem_if;
  logic [11:0] addr;
  logic [7:0] rdata;
  logic [7:0] wdata;
  logic we;
  modport core (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface

// ---- hw/swb_data_mem.sv ----
`timescale 1ns/1ps
`include "swb_consts.svh"
module swb_data_mem (
  // clock
  input wire logic clock,
  // access port
  swb_mem_if.mem port,
  // debug load port
  input wire logic load_en,
  input wire logic [11:0] load_addr,
  input wire logic [7:0] load_data
);
  logic [7:0] mem_array [0:`SWB_MEM_DEPTH-1];

  // write from the core wins over a debug load in the same cycle
  always_ff @(posedge clock) begin
    if (port.we) begin
      mem_array[port.addr] <= port.wdata;
    end else if (load_en) begin
      mem_array[load_addr] <= load_data;
    end
  end

  // asynchronous read so the value is ready in the read quarter
  assign port.rdata = mem_array[port.addr];
endmodule

// ---- hw/swb_exec.sv ----
`timescale 1ns/1ps
`include "swb_consts.svh"
module swb_exec (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  // bank pointer load
  input wire logic bank_load,
  input wire logic [3:0] bank_value,
  // working register load
  input wire logic w_load,
  input wire logic [7:0] w_value,
  // carry preset
  input wire logic carry_load,
  input wire logic carry_value,
  // data memory debug load
  input wire logic mem_load,
  input wire logic [11:0] mem_load_addr,
  input wire logic [7:0] mem_load_data,
  // state out
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [7:0] w_out,
  output logic [3:0] bank_out,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic negative_flag,
  output logic overflow_flag,
  output logic [11:0] last_addr,
  output logic [7:0] last_result
);
  swb_mem_if mbus ();

  swb_pkg::swb_phase_type phase_reg;
  logic active_reg;
  logic [15:0] ir_reg;
  logic [11:0] addr_reg;
  logic [7:0] operand_reg;
  logic [7:0] result_reg;
  logic [7:0] w_reg;
  logic [3:0] bank_pointer_reg;
  logic carry_reg;
  logic dc_reg;
  logic ov_reg;
  logic [8:0] diff_next;
  logic [4:0] low_next;
  logic sub_w_from_reg_borrow_op;
  logic dir_bit;
  logic acc_bit;
  logic q1_act;
  logic q2_act;
  logic q3_act;
  logic q4_act;

  // forms the 12-bit data address; access bank splits low and high halves
  function automatic logic [11:0] swb_addr(input logic acc, input logic [3:0] bank, input logic [7:0] f);
    logic [11:0] a;
    a = {bank, f};
    if (!acc) begin
      a = (f < `SWB_ACC_SPLIT) ? {`SWB_ACC_BANK_HI, f} : {`SWB_ACC_BANK_TOP, f};
    end
    return a;
  endfunction

  // fields of the held instruction
  assign sub_w_from_reg_borrow_op = (ir_reg[`SWB_OPC_HI:`SWB_OPC_LO] == `SWB_OPC_MATCH);
  assign dir_bit = ir_reg[`SWB_DIR_BIT];
  assign acc_bit = ir_reg[`SWB_ACC_BIT];

  // one strobe per quarter of a running instruction
  assign q1_act = active_reg && (phase_reg == swb_pkg::SWB_Q1);
  assign q2_act = active_reg && (phase_reg == swb_pkg::SWB_Q2);
  assign q3_act = active_reg && (phase_reg == swb_pkg::SWB_Q3);
  assign q4_act = active_reg && (phase_reg == swb_pkg::SWB_Q4);

  // two's complement subtract with borrow taken as the inverted carry
  assign diff_next = {1'b0, operand_reg} + {1'b0, ~w_reg} + {8'h00, carry_reg};
  assign low_next = {1'b0, operand_reg[3:0]} + {1'b0, ~w_reg[3:0]} + {4'h0, carry_reg};

  // memory port: write only in the last quarter when the result goes to f
  assign mbus.addr = addr_reg;
  assign mbus.wdata = result_reg;
  assign mbus.we = q4_act && dir_bit;

  swb_data_mem u_mem (
    .clock(clock),
    .port(mbus.mem),
    .load_en(mem_load),
    .load_addr(mem_load_addr),
    .load_data(mem_load_data)
  );

  // quarter sequencer; a new instruction is taken only when idle
  always_ff @(posedge clock) begin
    if (rst) begin
      active_reg <= 1'b0;
      phase_reg <= swb_pkg::SWB_Q1;
      ir_reg <= 16'h0000;
    end else if (!active_reg) begin
      if (instr_valid) begin
        active_reg <= 1'b1;
        phase_reg <= swb_pkg::SWB_Q1;
        ir_reg <= instr_word;
      end
    end else begin
      case (phase_reg)
        swb_pkg::SWB_Q1: phase_reg <= sub_w_from_reg_borrow_op ? swb_pkg::SWB_Q2 : swb_pkg::SWB_Q1;
        swb_pkg::SWB_Q2: phase_reg <= swb_pkg::SWB_Q3;
        swb_pkg::SWB_Q3: phase_reg <= swb_pkg::SWB_Q4;
        swb_pkg::SWB_Q4: phase_reg <= swb_pkg::SWB_Q1;
        default: phase_reg <= swb_pkg::SWB_Q1;
      endcase
      if (phase_reg == swb_pkg::SWB_Q4 || (phase_reg == swb_pkg::SWB_Q1 && !sub_w_from_reg_borrow_op)) begin
        active_reg <= 1'b0;
      end
    end
  end

  // decode quarter latches the address once, so the write goes where the read came from
  always_ff @(posedge clock) begin
    if (rst) begin
      addr_reg <= 12'h000;
    end else if (q1_act) begin
      addr_reg <= swb_addr(acc_bit, bank_pointer_reg, ir_reg[7:0]);
    end
  end

  // read quarter samples the asynchronous memory output
  always_ff @(posedge clock) begin
    if (rst) begin
      operand_reg <= 8'h00;
    end else if (q2_act) begin
      operand_reg <= mbus.rdata;
    end
  end

  // process quarter: the difference itself
  always_ff @(posedge clock) begin
    if (rst) begin
      result_reg <= 8'h00;
    end else if (q3_act) begin
      result_reg <= diff_next[7:0];
    end
  end

  // carry is the inverted borrow; the process quarter wins over a preset in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      carry_reg <= 1'b0;
    end else if (q3_act) begin
      carry_reg <= diff_next[8];
    end else if (carry_load) begin
      carry_reg <= carry_value;
    end
  end

  // nibble carry and signed overflow of the subtraction
  always_ff @(posedge clock) begin
    if (rst) begin
      dc_reg <= 1'b0;
      ov_reg <= 1'b0;
    end else if (q3_act) begin
      dc_reg <= low_next[4];
      ov_reg <= (operand_reg[7] != w_reg[7]) && (diff_next[7] != operand_reg[7]);
    end
  end

  // zero and negative follow the result byte
  always_ff @(posedge clock) begin
    if (rst) begin
      zero_flag <= 1'b0;
      negative_flag <= 1'b0;
    end else if (q3_act) begin
      zero_flag <= (diff_next[7:0] == 8'h00);
      negative_flag <= diff_next[7];
    end
  end

  // working register: result lands here in the write quarter when d is 0
  always_ff @(posedge clock) begin
    if (rst) begin
      w_reg <= `SWB_W_RST;
    end else if (q4_act && !dir_bit) begin
      w_reg <= result_reg;
    end else if (w_load && !active_reg) begin
      w_reg <= w_value;
    end
  end

  // bank pointer only changes while idle so an instruction sees a stable bank
  always_ff @(posedge clock) begin
    if (rst) begin
      bank_pointer_reg <= `SWB_BANK_RST;
    end else if (bank_load && !active_reg) begin
      bank_pointer_reg <= bank_value;
    end
  end

  // completion and trace outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      done <= 1'b0;
      illegal <= 1'b0;
      last_addr <= 12'h000;
      last_result <= 8'h00;
    end else begin
      done <= q4_act;
      illegal <= q1_act && !sub_w_from_reg_borrow_op;
      if (q4_act) begin
        last_addr <= addr_reg;
        last_result <= result_reg;
      end
    end
  end

  assign busy = active_reg;
  assign w_out = w_reg;
  assign bank_out = bank_pointer_reg;
  assign carry_flag = carry_reg;
  assign digit_carry_flag = dc_reg;
  assign overflow_flag = ov_reg;
endmodule

// ---- verif/swb_exec_sva.sv ----
`timescale 1ns/1ps
`include "swb_consts.svh"
module swb_exec_sva (
  // watched ports
  input wire logic clock,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] w_out,
  input wire logic [3:0] bank_out,
  input wire logic zero_flag,
  input wire logic negative_flag,
  input wire logic [11:0] last_addr,
  input wire logic [7:0] last_result
);
  logic take;
  logic [9:0] op_reg;
  logic [3:0] bank_reg;
  assign take = instr_valid && !busy && instr_word[15:10] == `SWB_OPC_MATCH;
  // keep the taken fields, the word may move on while busy
  always_ff @(posedge clock) begin
    if (take) begin
      op_reg <= instr_word[9:0];
      bank_reg <= bank_out;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_run;
    busy [*4] ##1 (done && !busy);
  endsequence
  a_four_quarters: assert property (take |=> s_run)
    else $error("quarter count wrong");
  a_dest_w: assert property (done && !op_reg[9] |-> w_out == last_result)
    else $error("w not written");
  a_dest_reg: assert property (done && op_reg[9] |-> w_out == $past(w_out, 4))
    else $error("w disturbed");
  a_access_bank: assert property (done && !op_reg[8] |-> last_addr == {{4{op_reg[7]}}, op_reg[7:0]})
    else $error("access bank address wrong");
  a_bank_pointer: assert property (done && op_reg[8] |-> last_addr == {bank_reg, op_reg[7:0]})
    else $error("banked address wrong");
  a_flags_match: assert property (done |-> zero_flag == (last_result == 8'h00) && negative_flag == last_result[7])
    else $error("flags disagree with result");
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic clock = 0, rst = 1, instr_valid = 0, bank_load = 0, w_load = 0, carry_load = 0, carry_value = 0, mem_load = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_value = 4'h0, bank_out;
  logic [7:0] w_value = 8'h00, mem_load_data = 8'h00, w_out, last_result;
  logic [11:0] mem_load_addr = 12'h000, last_addr;
  logic busy, done, carry_flag, zero_flag, negative_flag, illegal, digit_carry_flag, overflow_flag;
  int errors = 0, n_tests = 0;
  // 50 MHz core clock
  always #10 clock = ~clock;
  swb_exec i_dut (.clock, .rst, .instr_valid, .instr_word, .bank_load, .bank_value, .w_load, .w_value,
    .carry_load, .carry_value, .mem_load, .mem_load_addr, .mem_load_data, .busy, .done, .illegal, .w_out,
    .bank_out, .carry_flag, .digit_carry_flag, .zero_flag, .negative_flag, .overflow_flag, .last_addr,
    .last_result);
  task results;
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // preload w, carry, bank and one memory byte while idle; 12'hfff is a scratch byte
  task setup(input logic [7:0] w, input logic c, input logic [3:0] b, input logic [11:0] a, input logic [7:0] d);
    @(negedge clock);
    {w_load, carry_load, bank_load, mem_load} = 4'hf;
    {w_value, carry_value, bank_value, mem_load_addr, mem_load_data} = {w, c, b, a, d};
    @(negedge clock);
    {w_load, carry_load, bank_load, mem_load} = 4'h0;
  endtask
  // wait a bounded time for the done pulse; a hang goes straight to the report
  task wait_done;
    int i;
    for (i = 0; i < 8 && done !== 1'b1; i++) @(negedge clock);
    if (done !== 1'b1) begin
      errors++;
      results();
    end
  endtask
  // offer one word for one cycle, then wait for completion
  task issue(input logic [15:0] word);
    @(negedge clock);
    instr_valid = 1;
    instr_word = word;
    @(negedge clock);
    instr_valid = 0;
    wait_done();
  endtask
  task s_write_back;
    setup(8'h0d, 1'b1, 4'h0, 12'h019, 8'h19);
    issue(16'h5a19);
    chk(last_result, 8'h0c);
    chk(w_out, 8'h0d);
    chk(carry_flag, 1'b1);
    chk({digit_carry_flag, overflow_flag, zero_flag, negative_flag}, 4'h0);
    setup(8'h00, 1'b1, 4'h0, 12'hfff, 8'h00);
    issue(16'h5819);
    chk(w_out, 8'h0c);
  endtask
  task s_to_w;
    setup(8'h1a, 1'b0, 4'h0, 12'h01b, 8'h1b);
    issue(16'h581b);
    chk(w_out, 8'h00);
    chk({carry_flag, zero_flag}, 2'h3);
    chk({digit_carry_flag, overflow_flag}, 2'h2);
  endtask
  // a word outside the opcode is dropped after one quarter and changes nothing
  task s_illegal;
    setup(8'h5c, 1'b1, 4'h0, 12'hfff, 8'h00);
    @(negedge clock);
    instr_valid = 1;
    instr_word = 16'h1234;
    @(negedge clock);
    instr_valid = 0;
    chk(busy, 1'b1);
    @(negedge clock);
    chk({busy, illegal, done}, 3'h2);
    chk(w_out, 8'h5c);
  endtask
  // offer and loads held while busy must be ignored, one instruction only
  task s_refuse;
    setup(8'h10, 1'b1, 4'h0, 12'h030, 8'h50);
    @(negedge clock);
    instr_valid = 1;
    instr_word = 16'h5830;
    @(negedge clock);
    {w_load, w_value, bank_load, bank_value} = {1'b1, 8'haa, 1'b1, 4'h9};
    @(negedge clock);
    {instr_valid, w_load, bank_load} = 3'h0;
    wait_done();
    chk(w_out, 8'h40);
    chk(bank_out, 4'h0);
    @(negedge clock);
    chk({busy, done}, 2'h0);
  endtask
  // signed overflow written back through the bank pointer, then read back into w
  task s_overflow;
    setup(8'h01, 1'b1, 4'h2, 12'h220, 8'h80);
    issue(16'h5b20);
    chk(last_result, 8'h7f);
    chk({overflow_flag, carry_flag, digit_carry_flag, negative_flag}, 4'hc);
    chk(last_addr, 12'h220);
    chk(w_out, 8'h01);
    setup(8'h00, 1'b1, 4'h2, 12'hfff, 8'h00);
    issue(16'h5920);
    chk(w_out, 8'h7f);
  endtask
  task s_negative;
    setup(8'h0e, 1'b1, 4'h0, 12'h003, 8'h03);
    issue(16'h5a03);
    chk(last_result, 8'hf5);
    chk({carry_flag, negative_flag}, 2'h1);
  endtask
  // field 0x90 banked versus access bank high half, then field 0x10 in the low half
  task s_banks;
    setup(8'h01, 1'b1, 4'h5, 12'h590, 8'h44);
    issue(16'h5990);
    chk(w_out, 8'h43);
    chk(last_addr, 12'h590);
    setup(8'h01, 1'b1, 4'h5, 12'hf90, 8'h77);
    issue(16'h5890);
    chk(w_out, 8'h76);
    setup(8'h01, 1'b1, 4'h5, 12'h010, 8'h22);
    issue(16'h5810);
    chk(last_addr, 12'h010);
  endtask
  // reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    rst = 0;
    s_write_back();
    s_to_w();
    s_negative();
    s_banks();
    s_illegal();
    s_refuse();
    s_overflow();
    results();
  end
endmodule
bind swb_exec swb_exec_sva u_sva (.clock, .rst, .instr_valid, .instr_word, .busy, .done, .w_out, .bank_out,
  .zero_flag, .negative_flag, .last_addr, .last_result);
